// ==== rtl/chip_regs.sv ====
// codec host direct register port: index pointer, data window, status
`timescale 1ns/100ps
module chip_regs (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // host parallel bus, already synchronous to clk_in
  input  wire chip_pkg::chip_bus_t bus_in,
  output logic [7:0]            rdata_out,
  // core state
  input  wire logic             busy_in,
  input  wire logic             mode2_in,
  input  wire logic [7:0]       ind_rdata_in,
  input  wire logic             play_roll_in,
  input  wire logic             cap_roll_in,
  input  wire logic             timer_roll_in,
  input  wire logic             src_clear_in,
  input  wire logic             irq_pin_enable_in,
  input  wire logic             playback_format_change_flag_in,
  input  wire logic             capture_format_change_flag_in,
  input  wire logic             play_drq_raw_in,
  input  wire logic             cap_drq_raw_in,
  input  wire logic             sample_taken_in,
  input  wire logic             stereo_in,
  input  wire logic             wide_in,
  // indirect access and derived controls
  output chip_pkg::chip_ind_t   ind_out,
  output logic                  ind_rd_out,
  output logic                  dac_mute_out,
  output logic                  play_fmt_ok_out,
  output logic                  cap_fmt_ok_out,
  output logic                  playback_dma_request_out,
  output logic                  capture_dma_request_out,
  output logic                  irq_out,
  output logic                  pio_wr_out,
  output logic [7:0]            pio_data_out
);
  // ==========================================================================
  // decode
  // one shared compare, so no two direct registers can ever answer together
  function automatic logic addr_hit(input chip_pkg::chip_bus_t bus, input logic [1:0] addr);
    return bus.addr == addr;
  endfunction : addr_hit

  wire logic       hit_idx   = addr_hit(bus_in, chip_pkg::ADDR_INDEX);
  wire logic       hit_win   = addr_hit(bus_in, chip_pkg::ADDR_WINDOW);
  wire logic       hit_stat  = addr_hit(bus_in, chip_pkg::ADDR_STATUS);
  wire logic       hit_pio   = addr_hit(bus_in, chip_pkg::ADDR_PIO);

  // busy refuses everything but the status register, which stays readable
  wire logic       open      = !busy_in;

  wire logic       wr_idx    = bus_in.wr && hit_idx && open;
  wire logic       wr_win    = bus_in.wr && hit_win && open;
  wire logic       wr_stat   = bus_in.wr && hit_stat;
  wire logic       wr_pio    = bus_in.wr && hit_pio && open;
  wire logic       rd_win    = bus_in.rd && hit_win && open;
  wire logic       rd_stat   = bus_in.rd && hit_stat;

  // any of the three counters rolling over raises the shared flag
  wire logic       roll      = play_roll_in || cap_roll_in || timer_roll_in;

  logic [3:0] index_field_q;
  logic       upper_bank_select_q;
  logic       request_gating_q;
  logic       mode_change_flag_q;
  logic       int_q;
  logic       playback_ready_q;
  logic [1:0] pbyte_q;
  logic [7:0] pio_q;

  // ==========================================================================
  // index pointer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      index_field_q       <= chip_pkg::INDEX_RESET[3:0];
      upper_bank_select_q <= chip_pkg::INDEX_RESET[chip_pkg::IDX_UPPER_BIT];
      request_gating_q    <= chip_pkg::INDEX_RESET[chip_pkg::IDX_TRD_BIT];
      mode_change_flag_q  <= chip_pkg::INDEX_RESET[chip_pkg::IDX_MCE_BIT];
    end else if (wr_idx) begin
      index_field_q       <= bus_in.data[3:0];
      upper_bank_select_q <= bus_in.data[chip_pkg::IDX_UPPER_BIT];
      request_gating_q    <= bus_in.data[chip_pkg::IDX_TRD_BIT];
      mode_change_flag_q  <= bus_in.data[chip_pkg::IDX_MCE_BIT];
    end
  end

  // upper bank ignored in compatible mode
  wire logic       upper_eff = upper_bank_select_q && mode2_in;
  assign ind_out.index = {upper_eff, index_field_q};
  assign ind_out.wdata = bus_in.data;
  assign ind_out.wr    = wr_win;
  assign ind_rd_out    = rd_win;

  // ==========================================================================
  // interrupt: set wins over clear so no rollover is lost
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      int_q <= 1'b0;
    end else if (roll) begin
      int_q <= 1'b1;
    end else if (wr_stat || src_clear_in) begin
      int_q <= 1'b0;
    end
  end
  assign irq_out = int_q && irq_pin_enable_in;

  wire logic gate = request_gating_q && int_q;
  assign playback_dma_request_out = play_drq_raw_in && !gate;
  assign capture_dma_request_out  = cap_drq_raw_in && !gate;

  assign dac_mute_out    = mode_change_flag_q;
  assign play_fmt_ok_out = mode_change_flag_q || playback_format_change_flag_in;
  assign cap_fmt_ok_out  = mode_change_flag_q || capture_format_change_flag_in;

  // ==========================================================================
  // programmed-io playback byte tracking; needed bytes = (stereo+1)*(wide+1)
  // last byte index: mono 8-bit 0, stereo 8-bit or mono 16-bit 1, stereo 16-bit 3
  // format inputs are read live, so a format change mid-sample is the host's hazard
  wire logic [1:0] last_byte = {stereo_in && wide_in, stereo_in || wide_in};
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      playback_ready_q  <= 1'b1;
      pbyte_q <= 2'h0;
      pio_q   <= 8'h00;
    end else if (wr_pio && playback_ready_q) begin
      pio_q   <= bus_in.data;
      pbyte_q <= pbyte_q + 2'h1;
      playback_ready_q  <= (pbyte_q != last_byte);
    end else if (rd_stat && !playback_ready_q && sample_taken_in) begin
      pbyte_q <= 2'h0;
      playback_ready_q  <= 1'b1;
    end
  end
  assign pio_wr_out   = wr_pio && playback_ready_q;
  assign pio_data_out = pio_q;

  // left needed while in first half of the sample
  wire logic plr = stereo_in ? (wide_in ? !pbyte_q[1] : !pbyte_q[0]) : 1'b1;
  wire logic pul = wide_in ? pbyte_q[0] : 1'b1;

  // ==========================================================================
  // register images
  // init bit follows busy directly; nothing the host writes can reach it
  wire logic [7:0] index_image  = {busy_in,
                                   mode_change_flag_q,
                                   request_gating_q,
                                   upper_bank_select_q,
                                   index_field_q};

  // capture half of the status register is not modelled and reads zero
  wire logic [7:0] status_image = {4'h0,
                                   pul,
                                   plr,
                                   playback_ready_q,
                                   int_q};

  // ==========================================================================
  // read mux
  // combinational: data stands in the same cycle as the read strobe
  always_comb begin
    rdata_out = 8'h00;
    if (!open && !hit_stat) begin
      rdata_out = chip_pkg::BUSY_READ;
    end else begin
      unique case (bus_in.addr)
        chip_pkg::ADDR_INDEX: begin
          rdata_out = index_image;
        end
        chip_pkg::ADDR_WINDOW: begin
          rdata_out = ind_rdata_in;
        end
        chip_pkg::ADDR_STATUS: begin
          rdata_out = status_image;
        end
        chip_pkg::ADDR_PIO: begin
          rdata_out = 8'h00;
        end
      endcase
    end
  end
endmodule : chip_regs

// ==== rtl/chip_pkg.sv ====
// shared constants and types for the codec host register port
package chip_pkg;
  // ==========================================================================
  // direct register addresses (two address pins)
  localparam logic [1:0] ADDR_INDEX  = 2'h0;
  localparam logic [1:0] ADDR_WINDOW = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_PIO    = 2'h3;
  // ==========================================================================
  // index pointer fields
  localparam int IDX_INIT_BIT  = 7;
  localparam int IDX_MCE_BIT   = 6;
  localparam int IDX_TRD_BIT   = 5;
  localparam int IDX_UPPER_BIT = 4;
  // reset image 010x0000, undefined bit read as zero
  localparam logic [7:0] INDEX_RESET = 8'h40;
  localparam logic [7:0] BUSY_READ   = 8'h80;
  // ==========================================================================
  // status fields
  localparam int STAT_INT_BIT   = 0;
  localparam int STAT_PLAYBACK_READY_BIT  = 1;
  localparam int STAT_PLR_BIT   = 2;
  localparam int STAT_PUL_BIT   = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] data;
    logic       wr;
    logic       rd;
  } chip_bus_t;

  typedef struct packed {
    logic [4:0] index;
    logic [7:0] wdata;
    logic       wr;
  } chip_ind_t;
endpackage : chip_pkg

// ==== bench/chip_regs_props.sv ====
// checker for the codec host register port
`timescale 1ns/100ps
module chip_regs_props (
  // clock and reset
  input wire logic                clk_in,
  input wire logic                rst_n_in,
  // watched inputs
  input wire logic                busy_in,
  input wire logic                mode2_in,
  input wire logic                irq_pin_enable_in,
  input wire logic                play_drq_raw_in,
  input wire chip_pkg::chip_bus_t bus_in,
  // watched outputs
  input wire logic                irq_out,
  input wire logic                playback_dma_request_out,
  input wire logic                dac_mute_out,
  input wire logic [7:0]          rdata_out,
  input wire chip_pkg::chip_ind_t ind_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_busy; busy_in && bus_in.addr != 2'h2 |-> rdata_out == 8'h80; endproperty
  a_busy: assert property (p_busy) else $error("busy read");
  property p_init; bus_in.addr == 2'h0 |-> rdata_out[7] == busy_in; endproperty
  a_init: assert property (p_init) else $error("init bit");
  property p_mute; bus_in.addr == 2'h0 && !busy_in |-> rdata_out[6] == dac_mute_out; endproperty
  a_mute: assert property (p_mute) else $error("mute");
  property p_mask; !irq_pin_enable_in |-> !irq_out; endproperty
  a_mask: assert property (p_mask) else $error("irq mask");
  property p_flow; play_drq_raw_in && irq_pin_enable_in && !irq_out |-> playback_dma_request_out; endproperty
  a_flow: assert property (p_flow) else $error("dma flow");
  property p_idx; bus_in.wr && bus_in.addr == 2'h0 && !busy_in
    |=> ind_out.index[3:0] == $past(bus_in.data[3:0]); endproperty
  a_idx: assert property (p_idx) else $error("index");
  property p_win; bus_in.wr && bus_in.addr == 2'h1 && !busy_in |-> ind_out.wr && ind_out.wdata == bus_in.data;
  endproperty
  a_win: assert property (p_win) else $error("window");
  property p_upper; !mode2_in |-> !ind_out.index[4]; endproperty
  a_upper: assert property (p_upper) else $error("upper bank");
endmodule : chip_regs_props
bind chip_regs chip_regs_props chip_regs_props_inst (.*);

// ==== bench/chip_host_model.sv ====
// host processor model on the parallel register bus
`timescale 1ns/100ps
module chip_host_model (
  input  wire logic           clk_in,
  output chip_pkg::chip_bus_t bus_out
);
  initial bus_out = '0;
  // one strobe cycle, then data flips so a stale byte never looks live
  task automatic cyc(input logic [1:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_in);
    bus_out <= '{a, d, w, !w};
    @(negedge clk_in);
    bus_out <= '{a, ~d, 1'b0, 1'b0};
  endtask : cyc
endmodule : chip_host_model

// ==== bench/codec_host_index_status_port_bench.sv ====
// self-checking bench for the codec host register port
`timescale 1ns/100ps
module codec_host_index_status_port_bench;
  logic clk_in, rst_n_in, busy_in, mode2_in, play_roll_in, irq_pin_enable_in, play_drq_raw_in;
  logic playback_format_change_flag_in, capture_format_change_flag_in, stereo_in, wide_in, irq_out, playback_dma_request_out;
  logic sample_taken_in, capture_dma_request_out, dac_mute_out, play_fmt_ok_out, cap_fmt_ok_out;
  logic [7:0] ind_rdata_in, rdata_out, v, pio_data_out, exp_q[$];
  logic [31:0] seed;
  chip_pkg::chip_bus_t bus_in;
  int n_mismatch = 0, check_count = 0;
  chip_host_model chip_host_model_inst (.clk_in, .bus_out(bus_in));
  chip_regs chip_regs_inst (.clk_in, .rst_n_in, .bus_in, .rdata_out, .busy_in, .mode2_in, .ind_rdata_in,
    .play_roll_in, .cap_roll_in(1'b0), .timer_roll_in(1'b0), .src_clear_in(1'b0), .irq_pin_enable_in, .playback_format_change_flag_in,
    .capture_format_change_flag_in, .play_drq_raw_in, .cap_drq_raw_in(play_drq_raw_in), .sample_taken_in, .stereo_in, .wide_in,
    .ind_out(), .ind_rd_out(), .dac_mute_out, .play_fmt_ok_out, .cap_fmt_ok_out, .playback_dma_request_out,
    .capture_dma_request_out, .irq_out, .pio_wr_out(), .pio_data_out);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    check_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD t=%0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    chip_host_model_inst.cyc(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    chip_host_model_inst.cyc(a, 8'h00, 1'b0);
  endtask : rd
  task automatic pulse();
    @(negedge clk_in);
    play_roll_in = 1'b1;
    @(negedge clk_in);
    play_roll_in = 1'b0;
  endtask : pulse
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    n_mismatch++;
    end_of_test();
  end
  // read data is combinational, so it is judged at the edge that takes the strobe
  always @(posedge clk_in) if (bus_in.rd === 1'b1 && exp_q.size() > 0) chk(rdata_out, exp_q.pop_front());
  initial begin
    {rst_n_in, busy_in, play_roll_in, irq_pin_enable_in, play_drq_raw_in, playback_format_change_flag_in, capture_format_change_flag_in, stereo_in, wide_in} = '0;
    sample_taken_in = 1'b0;
    mode2_in = 1'b1;
    ind_rdata_in = 8'h00;
    seed = 32'hef0c_53af;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    rd(2'h0, 8'h40);
    $display("reset done");
    repeat (5) begin
      seed = lfsr(seed);
      v = seed[7:0] | 8'h40;
      {playback_format_change_flag_in, capture_format_change_flag_in, stereo_in, wide_in} = seed[11:8];
      ind_rdata_in = seed[23:16];
      wr(2'h0, v);
      rd(2'h0, {1'b0, v[6:0]});
      chk({5'h0, dac_mute_out, play_fmt_ok_out, cap_fmt_ok_out}, 8'h07);
      wr(2'h1, seed[31:24]);
      rd(2'h1, seed[23:16]);
    end
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h00);
    chk({5'h0, dac_mute_out, play_fmt_ok_out, cap_fmt_ok_out}, {5'h0, 1'b0, playback_format_change_flag_in, capture_format_change_flag_in});
    $display("index done");
    busy_in = 1'b1;
    mode2_in = 1'b0;
    wr(2'h0, 8'h33);
    rd(2'h0, 8'h80);
    rd(2'h1, 8'h80);
    busy_in = 1'b0;
    mode2_in = 1'b1;
    rd(2'h0, 8'h00);
    $display("busy done");
    irq_pin_enable_in = 1'b1;
    play_drq_raw_in = 1'b1;
    wr(2'h0, 8'h20);
    pulse();
    repeat (3) @(negedge clk_in);
    chk({7'h0, irq_out}, 8'h01);
    chk({7'h0, playback_dma_request_out}, 8'h00);
    chk({7'h0, capture_dma_request_out}, 8'h00);
    wr(2'h2, 8'h5a);
    chk({7'h0, irq_out}, 8'h00);
    chk({7'h0, playback_dma_request_out}, 8'h01);
    chk({7'h0, capture_dma_request_out}, 8'h01);
    irq_pin_enable_in = 1'b0;
    pulse();
    chk({7'h0, irq_out}, 8'h00);
    irq_pin_enable_in = 1'b1;
    #1 chk({7'h0, irq_out}, 8'h01);
    $display("interrupt done");
    wr(2'h2, 8'h00);
    {stereo_in, wide_in} = 2'b10;
    rd(2'h2, 8'h0e);
    wr(2'h3, 8'ha5);
    chk(pio_data_out, 8'ha5);
    rd(2'h2, 8'h0a);
    wr(2'h3, 8'h3c);
    rd(2'h2, 8'h0c);
    wr(2'h3, 8'h77);
    chk(pio_data_out, 8'h3c);
    sample_taken_in = 1'b1;
    rd(2'h2, 8'h0c);
    sample_taken_in = 1'b0;
    rd(2'h2, 8'h0e);
    $display("pio done");
    end_of_test();
  end
endmodule : codec_host_index_status_port_bench
